// file: hw/dcti_monitor.sv
// dual-channel torque-inhibit monitor top level
`timescale 1ns/10ps
`default_nettype none
//
// Overview of operation
// - both inputs low blocks motor power, refuses start, reports a trip and turns the status output on.
// - both inputs high permits running under software control with the status output off.
// - inputs in opposite states trip the drive, block starting and keep the status output off.
// - a disagreement lasting up to 1.6 s never produces a fault.
// - a disagreement lasting longer than 3.0 s always produces a fault.
// - once declared the fault latches by itself, keeps the drive tripped and the status output off.
// - only a power-up reset leaves the fault; input changes never clear it.
// - low test pulses shorter than 2 ms on either input are ignored.
// - an input going low is acted on only after it has stayed low for the filter time.
module dcti_monitor
    import dcti_pkg::*;
#(
    parameter int unsigned     FILT_CYC = FILTER_CYC,
    parameter longint unsigned DET_CYC  = FAULT_SET_CYC
) (
    input  wire logic   clk,
    input  wire logic   arst_n,
    input  wire logic   ce,
    input  wire logic   inhibit_input_a,
    input  wire logic   inhibit_input_b,
    input  wire logic   sw_run_req,
    output logic        motor_power_en,
    output logic        inhibit_status_out_pos,
    output logic        inhibit_status_out_neg,
    output dcti_status_t status
);
    localparam int unsigned TW = $clog2(DET_CYC + 1);

    // refuse settings the timer cannot serve; the full-size default must sit
    // strictly between the tolerated and the always-faulting disagreement times
    if (DET_CYC < 2) begin
        $error("detection time too short");
    end
    if (DET_CYC == FAULT_SET_CYC && (DET_CYC <= TOL_CYC || DET_CYC >= FAULT_CYC)) begin
        $error("detection time outside tolerance window");
    end
    if (FILT_CYC < 2) begin
        $error("filter time too short");
    end

    ////////////////////////////////////////////////////////////////////////////
    // channel filters
    logic a_lvl;
    logic b_lvl;

    dcti_chan_filter #(.FILT_CYC(FILT_CYC)) u_filt_a (
        .clk     (clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .pin_in  (inhibit_input_a),
        .level_q (a_lvl)
    );

    dcti_chan_filter #(.FILT_CYC(FILT_CYC)) u_filt_b (
        .clk     (clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .pin_in  (inhibit_input_b),
        .level_q (b_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state and disagreement timer; the timer sees filtered levels only,
    // so a short test pulse never starts it
    dcti_state_t   state_q, state_d;
    logic [TW-1:0] tmr_q, tmr_d;
    logic          disagree;

    always_comb begin
        disagree = a_lvl ^ b_lvl;
        state_d  = state_q;
        tmr_d    = tmr_q;
        unique case (state_q)
            DCTI_ST_FAULT: begin
                // only arst_n (power-up) leaves this state
                state_d = DCTI_ST_FAULT;
            end
            DCTI_ST_RUN_OK, DCTI_ST_INHIBIT, DCTI_ST_DISAGREE: begin
                if (disagree) begin
                    if (tmr_q >= TW'(DET_CYC - 1)) begin
                        state_d = DCTI_ST_FAULT;
                    end else begin
                        tmr_d   = tmr_q + TW'(1);
                        state_d = DCTI_ST_DISAGREE;
                    end
                end else begin
                    tmr_d   = '0;
                    state_d = a_lvl ? DCTI_ST_RUN_OK : DCTI_ST_INHIBIT;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= DCTI_ST_INHIBIT;
            tmr_q   <= '0;
        end else if (ce) begin
            state_q <= state_d;
            tmr_q   <= tmr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, registered; status output shows safe state only with both low
    // a latched fault forces the status output off even with both inputs low
    logic         pwr_q, pwr_d;
    logic         sto_q, sto_d;
    dcti_status_t stat_q, stat_d;

    always_comb begin
        sto_d              = (state_d == DCTI_ST_INHIBIT);
        pwr_d              = (state_d == DCTI_ST_RUN_OK) && sw_run_req;
        stat_d.run_permit  = (state_d == DCTI_ST_RUN_OK);
        stat_d.start_block = (state_d != DCTI_ST_RUN_OK);
        stat_d.trip        = (state_d != DCTI_ST_RUN_OK);
        stat_d.fault       = (state_d == DCTI_ST_FAULT);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pwr_q  <= 1'b0;
            sto_q  <= 1'b0;
            stat_q <= '{run_permit: 1'b0, start_block: 1'b1, trip: 1'b1, fault: 1'b0};
        end else if (ce) begin
            pwr_q  <= pwr_d;
            sto_q  <= sto_d;
            stat_q <= stat_d;
        end
    end

    assign motor_power_en         = pwr_q;
    assign inhibit_status_out_pos = sto_q;
    assign inhibit_status_out_neg = !sto_q;
    assign status                 = stat_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_both_low;
        !a_lvl && !b_lvl;
    endsequence

    sequence s_fault_entered;
        state_q == DCTI_ST_FAULT;
    endsequence

    sequence s_both_high;
        a_lvl && b_lvl;
    endsequence

    // ce is part of it: a frozen cycle must not count toward the fault
    sequence s_disagree_live;
        ce && disagree && state_q != DCTI_ST_FAULT;
    endsequence

    sequence s_fault_outputs;
        !sto_q && !motor_power_en && status.fault && status.trip && status.start_block;
    endsequence

    chk_both_low_safe: assert property (@(posedge clk) disable iff (!arst_n)
        ce && state_q != DCTI_ST_FAULT ##0 s_both_low |=> (!ce || (inhibit_status_out_pos && !motor_power_en)))
        else $error("both low but not inhibited");
    chk_both_high_run: assert property (@(posedge clk) disable iff (!arst_n)
        ce && state_q != DCTI_ST_FAULT && a_lvl && b_lvl && sw_run_req |=> (!ce || (motor_power_en && !sto_q)))
        else $error("both high but run refused");
    chk_disagree_trip: assert property (@(posedge clk) disable iff (!arst_n)
        ce && disagree |=> (!ce || (!motor_power_en && !sto_q && status.start_block)))
        else $error("disagreement not tripped");
    chk_no_early_fault: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(state_q == DCTI_ST_FAULT) |-> $past(tmr_q) == TW'(DET_CYC - 1))
        else $error("fault before detection time");
    chk_fault_on_time: assert property (@(posedge clk) disable iff (!arst_n)
        s_disagree_live ##0 tmr_q == TW'(DET_CYC - 1) |=> s_fault_entered)
        else $error("fault not declared in time");
    chk_fault_latched: assert property (@(posedge clk) disable iff (!arst_n)
        s_fault_entered |=> s_fault_entered ##0 (!sto_q && !motor_power_en))
        else $error("fault latch released");
    chk_timer_clear: assert property (@(posedge clk) disable iff (!arst_n)
        ce && !disagree && state_q != DCTI_ST_FAULT |=> (!ce || tmr_q == '0))
        else $error("timer not cleared on agreement");
    chk_timer_step: assert property (@(posedge clk) disable iff (!arst_n)
        s_disagree_live ##0 tmr_q < TW'(DET_CYC - 1) |=> tmr_q == $past(tmr_q) + TW'(1))
        else $error("timer did not count disagreement");
    chk_fault_needs_split: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(state_q == DCTI_ST_FAULT) |-> $past(disagree))
        else $error("fault without disagreement");
    chk_fault_outputs: assert property (@(posedge clk) disable iff (!arst_n)
        s_fault_entered |-> s_fault_outputs)
        else $error("fault state outputs wrong");

    // truth table: status bits of the two clean states, then power and status gating
    chk_agree_resume: assert property (@(posedge clk) disable iff (!arst_n)
        ce && state_q != DCTI_ST_FAULT ##0 s_both_high |=> status.run_permit && !status.trip)
        else $error("both high but not run permitted");
    chk_inhibit_state: assert property (@(posedge clk) disable iff (!arst_n)
        ce && state_q != DCTI_ST_FAULT ##0 s_both_low |=> status.trip && status.start_block && !status.run_permit)
        else $error("both low but trip not reported");
    chk_power_needs_high: assert property (@(posedge clk) disable iff (!arst_n)
        ce && !(a_lvl && b_lvl) |=> !motor_power_en && status.start_block && status.trip)
        else $error("power allowed without both inputs high");
    chk_power_needs_sw: assert property (@(posedge clk) disable iff (!arst_n)
        ce && !sw_run_req |=> !motor_power_en)
        else $error("power allowed without run request");
    chk_status_only_safe: assert property (@(posedge clk) disable iff (!arst_n)
        inhibit_status_out_pos |-> status.start_block && !status.fault && !motor_power_en)
        else $error("status output on outside safe state");

    // nothing moves while the enable is low
    chk_ce_freeze: assert property (@(posedge clk) disable iff (!arst_n)
        !ce |=> $stable(state_q) && $stable(tmr_q) && $stable(status) && $stable(motor_power_en))
        else $error("state moved with enable low");
endmodule
`default_nettype wire

// file: common/dcti_pkg.sv
// package: constants and types for the dual-channel torque-inhibit monitor
package dcti_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned CLK_NS          = 10;
    localparam int unsigned FILTER_US       = 6000;   // low-going filter time, typical
    localparam int unsigned PULSE_MAX_US    = 2000;   // test pulses shorter than this are ignored
    localparam int unsigned TOL_MS          = 1600;   // disagreement never faults below this
    localparam int unsigned FAULT_MS        = 3000;   // disagreement always faults beyond this
    localparam int unsigned FAULT_SET_MS    = 2300;   // chosen detection point, between the two
    localparam int unsigned FILTER_CYC      = (FILTER_US * 1000) / CLK_NS;
    localparam int unsigned PULSE_MAX_CYC   = (PULSE_MAX_US * 1000) / CLK_NS;
    localparam longint unsigned FAULT_SET_CYC = (64'(FAULT_SET_MS) * 1_000_000) / CLK_NS;
    localparam longint unsigned TOL_CYC     = (64'(TOL_MS) * 1_000_000) / CLK_NS;
    localparam longint unsigned FAULT_CYC   = (64'(FAULT_MS) * 1_000_000) / CLK_NS;

    typedef enum logic [1:0] {
        DCTI_ST_RUN_OK,
        DCTI_ST_INHIBIT,
        DCTI_ST_DISAGREE,
        DCTI_ST_FAULT
    } dcti_state_t;

    typedef struct packed {
        logic run_permit;
        logic start_block;
        logic trip;
        logic fault;
    } dcti_status_t;
endpackage

// file: hw/dcti_chan_filter.sv
// one safety input channel: synchroniser and low-going filter
`timescale 1ns/10ps
`default_nettype none
module dcti_chan_filter
    import dcti_pkg::*;
#(
    parameter int unsigned FILT_CYC = FILTER_CYC
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic ce,
    input  wire logic pin_in,
    output logic      level_q
);
    localparam int unsigned CW = $clog2(FILT_CYC + 1);

    // below two samples the counter cannot tell a pulse from a level
    if (FILT_CYC < 2) begin
        $error("filter too short");
    end

    logic [2:0]    sync_q, sync_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          level_d;
    logic          stable_lvl;
    logic          agree;

    always_comb begin
        sync_d     = {sync_q[1:0], pin_in};
        agree      = sync_q[1] == sync_q[2];
        stable_lvl = sync_q[2];
        cnt_d      = cnt_q;
        level_d    = level_q;
        if (agree && !stable_lvl) begin
            // low must persist the full time; short test pulses die here
            if (cnt_q >= CW'(FILT_CYC - 1)) begin
                level_d = 1'b0;
            end else begin
                cnt_d = cnt_q + CW'(1);
            end
        end else if (agree) begin
            cnt_d   = '0;
            level_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_q  <= 3'h0;
            cnt_q   <= '0;
            level_q <= 1'b0;
        end else if (ce) begin
            sync_q  <= sync_d;
            cnt_q   <= cnt_d;
            level_q <= level_d;
        end
    end

    chk_pulse_ignored: assert property (@(posedge clk) disable iff (!arst_n)
        ce && level_q && agree && !stable_lvl && cnt_q < CW'(FILT_CYC - 1) |=> level_q)
        else $error("level fell before filter time");
    chk_low_needs_time: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(level_q) |-> cnt_q == CW'(FILT_CYC - 1))
        else $error("filter released before full time");
endmodule
`default_nettype wire

// file: tb/dcti_relay_model.sv
// model of the external safety relay that drives both inhibit inputs
`timescale 1ns/10ps
`default_nettype none
module dcti_relay_model (
    input  wire logic clk,
    output logic      inhibit_input_a,
    output logic      inhibit_input_b
);
    initial begin
        inhibit_input_a = 1'b0;
        inhibit_input_b = 1'b0;
    end
    // both contacts move on the same edge, zero skew
    task automatic set_both(input logic a, input logic b);
        @(negedge clk);
        inhibit_input_a = a;
        inhibit_input_b = b;
    endtask
    // low test pulse on one channel; caller keeps it short
    task automatic pulse(input bit ch_b, input int len);
        @(negedge clk);
        if (ch_b) inhibit_input_b = 1'b0;
        else inhibit_input_a = 1'b0;
        repeat (len) @(negedge clk);
        inhibit_input_a = 1'b1;
        inhibit_input_b = 1'b1;
    endtask
endmodule
`default_nettype wire

// file: tb/dcti_monitor_test.sv
// self-checking bench for the torque-inhibit monitor
`timescale 1ns/10ps
`default_nettype none
module dcti_monitor_test;
    import dcti_pkg::*;
    localparam int unsigned     FILT = 16;
    localparam longint unsigned DET  = 64;
    localparam int              TOL  = 44;  // 1.6 s scaled to DET
    typedef struct { logic a, b, run, mpe, pos; logic [3:0] st; } dcti_row_t;
    logic         clk, arst_n, ce, sw_run_req, in_a, in_b, mpe, pos, neg;
    dcti_status_t status;
    int           errors, total_checks;
    dcti_row_t    rows[5] = '{'{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 4'h8}, '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h8},
                              '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 4'h6}, '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h6},
                              '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 4'h8}};

    dcti_monitor #(.FILT_CYC(FILT), .DET_CYC(DET)) u_dut (
        .clk(clk), .arst_n(arst_n), .ce(ce), .inhibit_input_a(in_a), .inhibit_input_b(in_b),
        .sw_run_req(sw_run_req), .motor_power_en(mpe), .inhibit_status_out_pos(pos),
        .inhibit_status_out_neg(neg), .status(status));
    dcti_relay_model u_relay (.clk(clk), .inhibit_input_a(in_a), .inhibit_input_b(in_b));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_outs(input logic e_mpe, input logic e_pos, input logic [3:0] e_st);
        chk("motor_power_en", {3'h0, e_mpe}, {3'h0, mpe});
        chk("status_out_pos", {3'h0, e_pos}, {3'h0, pos});
        chk("status_out_neg", {3'h0, ~e_pos}, {3'h0, neg});
        chk("status", e_st, status);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // bounded wait for the fault latch
    task automatic wait_fault(input int lim);
        int n;
        n = 0;
        while (status.fault !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) begin
            errors++;
            $display("wrong value fault wait expected 1 seen %b", status.fault);
            finish_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        sw_run_req = 1'b0;
        errors = 0;
        total_checks = 0;
        repeat (5) @(negedge clk);
        chk_outs(1'b0, 1'b0, 4'h6);
        arst_n = 1'b1;
        $display("reset test done");
        foreach (rows[i]) begin
            u_relay.set_both(rows[i].a, rows[i].b);
            sw_run_req = rows[i].run;
            repeat (FILT + 10) @(negedge clk);
            chk_outs(rows[i].mpe, rows[i].pos, rows[i].st);
        end
        $display("truth table test done");
        // short pulse on each channel, then one just under the filter time
        u_relay.pulse(1'b0, 5);
        u_relay.pulse(1'b1, 5);
        chk_outs(1'b1, 1'b0, 4'h8);
        u_relay.pulse(1'b0, FILT - 2);
        repeat (FILT + 10) @(negedge clk);
        chk_outs(1'b1, 1'b0, 4'h8);
        $display("pulse test done");
        // two short disagreements back to back; timer must restart
        for (int k = 0; k < 2; k++) begin
            u_relay.set_both(1'b0, 1'b1);
            repeat (FILT + 6) @(negedge clk);
            chk_outs(1'b0, 1'b0, 4'h6);
            repeat (TOL - 12) @(negedge clk);
            u_relay.set_both(1'b1, 1'b1);
            repeat (12) @(negedge clk);
            chk_outs(1'b1, 1'b0, 4'h8);
        end
        $display("short disagreement test done");
        u_relay.set_both(1'b1, 1'b0);
        wait_fault(FILT + 90);
        chk_outs(1'b0, 1'b0, 4'h7);
        u_relay.set_both(1'b1, 1'b1);
        repeat (FILT + 10) @(negedge clk);
        chk_outs(1'b0, 1'b0, 4'h7);
        u_relay.set_both(1'b0, 1'b0);
        repeat (FILT + 10) @(negedge clk);
        chk_outs(1'b0, 1'b0, 4'h7);
        arst_n = 1'b0;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        u_relay.set_both(1'b1, 1'b1);
        repeat (FILT + 10) @(negedge clk);
        chk_outs(1'b1, 1'b0, 4'h8);
        $display("fault latch test done");
        // frozen enable: inputs drop but nothing may move until it returns
        ce = 1'b0;
        u_relay.set_both(1'b0, 1'b0);
        repeat (FILT + 10) @(negedge clk);
        chk_outs(1'b1, 1'b0, 4'h8);
        ce = 1'b1;
        repeat (FILT + 10) @(negedge clk);
        chk_outs(1'b0, 1'b1, 4'h6);
        $display("clock enable test done");
        finish_test();
    end
endmodule
`default_nettype wire
